// ==== hdl/low_power_domain_power_control.sv ====
// Local design decision: the APB slave port.
`timescale 1ns/1ps
module low_power_domain_power_control (
  // clock, reset, enable
  input  wire  logic        pclk,
  input  wire  logic        presetn,
  input  wire  logic        ce,
  // apb slave
  input  wire  logic        psel,
  input  wire  logic        penable,
  input  wire  logic        pwrite,
  input  wire  logic [11:0] paddr,
  input  wire  logic [31:0] pwdata,
  input  wire  logic [3:0]  pstrb,
  output logic              pready,
  output logic [31:0]       prdata,
  output logic              pslverr,
  // from sleep sequencer and cpu, same clock
  input  wire  logic        sleep_active,
  input  wire  logic        lp_mode,
  input  wire  logic        cpu_pd,
  // domain switches
  output logic              periph_power_on,
  output logic              periph_isolate,
  output logic              slow_mem_power_on,
  output logic              slow_mem_isolate,
  output logic              fast_mem_power_on,
  output logic              fast_mem_isolate
);
  import lp_pwr_pkg::*;

  logic [31:0] pwc;
  logic [31:0] next_pwc;
  logic [31:0] next_prdata;
  dom_ctrl_s   ctrl     [NUM_DOMS];
  dom_out_s    dom      [NUM_DOMS];
  dom_out_s    next_dom [NUM_DOMS];
  logic        hit_pwc;
  logic        hit_status;
  logic        wr_acc;
  logic [31:0] strb_mask;
  logic [31:0] status_word;

  // bus decode; zero wait states so pready is simply high
  assign hit_pwc    = (paddr == lp_pwr_pkg::PWC_ADDR);
  assign hit_status = (paddr == lp_pwr_pkg::STATUS_ADDR);
  assign wr_acc     = psel & penable & pwrite & ce;
  assign pready     = 1'b1;
  assign pslverr    = psel & penable & ~(hit_pwc | hit_status);  // unmapped answers with error
  assign strb_mask  = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};

  // status shows the registered switch state, low six bits
  assign status_word = {26'h0,
                        dom[DOM_FAST].isolate, dom[DOM_FAST].power_on,
                        dom[DOM_SLOW].isolate, dom[DOM_SLOW].power_on,
                        dom[DOM_PERI].isolate, dom[DOM_PERI].power_on};

  // control register write, byte lanes honoured, reserved bits stay zero
  always_comb begin
    next_pwc = pwc;
    if (wr_acc && hit_pwc) begin
      next_pwc = ((pwdata & strb_mask) | (pwc & ~strb_mask)) & PWC_WR_MASK;
    end
  end

  // read data captured in the setup cycle so it comes from a flop
  always_comb begin
    next_prdata = prdata;
    if (psel && !penable && !pwrite) begin
      if (hit_pwc) begin
        next_prdata = pwc;
      end else if (hit_status) begin
        next_prdata = status_word;
      end else begin
        next_prdata = 32'h0000_0000;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pwc    <= PWC_RESET;
      prdata <= 32'h0000_0000;
    end else if (ce) begin
      pwc    <= next_pwc;
      prdata <= next_prdata;
    end
  end

  // field unpacking; the peripheral domain has no low-power controls
  always_comb begin
    ctrl[DOM_PERI] = '{sleep_pd_en:     pwc[PERI_PD_EN_BIT],
                       force_on:        pwc[PERI_FORCE_ON_BIT],
                       force_off:       pwc[PERI_FORCE_OFF_BIT],
                       lp_force_on:     1'b0,
                       lp_force_off:    1'b0,
                       follow_cpu_sel:  1'b0,
                       force_isolate:   pwc[PERI_FORCE_ISO_BIT],
                       force_unisolate: pwc[PERI_FORCE_UNISO_BIT]};
    ctrl[DOM_SLOW] = '{sleep_pd_en:     pwc[SLOW_PD_EN_BIT],
                       force_on:        pwc[SLOW_FORCE_ON_BIT],
                       force_off:       pwc[SLOW_FORCE_OFF_BIT],
                       lp_force_on:     pwc[SLOW_LP_ON_BIT],
                       lp_force_off:    pwc[SLOW_LP_OFF_BIT],
                       follow_cpu_sel:  pwc[SLOW_FOLLOW_CPU_BIT],
                       force_isolate:   pwc[SLOW_FORCE_ISO_BIT],
                       force_unisolate: pwc[SLOW_FORCE_UNISO_BIT]};
    ctrl[DOM_FAST] = '{sleep_pd_en:     pwc[FAST_PD_EN_BIT],
                       force_on:        pwc[FAST_FORCE_ON_BIT],
                       force_off:       pwc[FAST_FORCE_OFF_BIT],
                       lp_force_on:     pwc[FAST_LP_ON_BIT],
                       lp_force_off:    pwc[FAST_LP_OFF_BIT],
                       follow_cpu_sel:  pwc[FAST_FOLLOW_CPU_BIT],
                       force_isolate:   pwc[FAST_FORCE_ISO_BIT],
                       force_unisolate: pwc[FAST_FORCE_UNISO_BIT]};
  end

  // one power/isolation switch per domain
  for (genvar d = 0; d < NUM_DOMS; d++) begin : g_dom
    logic pd_source;
    logic auto_on;

    // low-power pd source: cpu or sequencer
    assign pd_source = (lp_mode && ctrl[d].follow_cpu_sel) ? cpu_pd : sleep_active;

    // automatic path, used when neither force_on nor force_off is set
    always_comb begin
      auto_on = ~(ctrl[d].sleep_pd_en & pd_source);
      if (lp_mode && ctrl[d].lp_force_on) begin
        auto_on = 1'b1;
      end else if (lp_mode && ctrl[d].lp_force_off) begin
        auto_on = 1'b0;
      end
    end

    // force-on wins when both set: keeping power is the safer failure
    always_comb begin
      next_dom[d] = dom[d];
      if (ctrl[d].force_on) begin
        next_dom[d].power_on = 1'b1;
      end else if (ctrl[d].force_off) begin
        next_dom[d].power_on = 1'b0;
      end else begin
        next_dom[d].power_on = auto_on;
      end
      // isolation tracks the next power state, forced or automatic, unless forced itself
      if (ctrl[d].force_isolate) begin
        next_dom[d].isolate = 1'b1;
      end else if (ctrl[d].force_unisolate) begin
        next_dom[d].isolate = 1'b0;
      end else begin
        next_dom[d].isolate = ~next_dom[d].power_on;
      end
    end

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        dom[d] <= DOM_OUT_RESET;
      end else if (ce) begin
        dom[d] <= next_dom[d];
      end
    end
  end

  // switch outputs straight from the flops
  assign periph_power_on   = dom[DOM_PERI].power_on;
  assign periph_isolate    = dom[DOM_PERI].isolate;
  assign slow_mem_power_on = dom[DOM_SLOW].power_on;
  assign slow_mem_isolate  = dom[DOM_SLOW].isolate;
  assign fast_mem_power_on = dom[DOM_FAST].power_on;
  assign fast_mem_isolate  = dom[DOM_FAST].isolate;

endmodule : low_power_domain_power_control

// ==== hdl/lp_pwr_pkg.sv ====
package lp_pwr_pkg;

  // register indices; byte address is four times the index
  localparam logic [9:0]  PWC_INDEX    = 10'h020;
  localparam logic [9:0]  STATUS_INDEX = 10'h03f;
  localparam logic [11:0] PWC_ADDR     = {PWC_INDEX, 2'b00};
  localparam logic [11:0] STATUS_ADDR  = {STATUS_INDEX, 2'b00};

  // control register field positions
  localparam int FAST_FORCE_UNISO_BIT = 0;
  localparam int FAST_FORCE_ISO_BIT   = 1;
  localparam int SLOW_FORCE_UNISO_BIT = 2;
  localparam int SLOW_FORCE_ISO_BIT   = 3;
  localparam int PERI_FORCE_ISO_BIT   = 4;
  localparam int PERI_FORCE_UNISO_BIT = 5;
  localparam int FAST_FOLLOW_CPU_BIT  = 6;
  localparam int FAST_LP_OFF_BIT      = 7;
  localparam int FAST_LP_ON_BIT       = 8;
  localparam int SLOW_FOLLOW_CPU_BIT  = 9;
  localparam int SLOW_LP_OFF_BIT      = 10;
  localparam int SLOW_LP_ON_BIT       = 11;
  localparam int FAST_FORCE_OFF_BIT   = 12;
  localparam int FAST_FORCE_ON_BIT    = 13;
  localparam int FAST_PD_EN_BIT       = 14;
  localparam int SLOW_FORCE_OFF_BIT   = 15;
  localparam int SLOW_FORCE_ON_BIT    = 16;
  localparam int SLOW_PD_EN_BIT       = 17;
  localparam int PERI_FORCE_OFF_BIT   = 18;
  localparam int PERI_FORCE_ON_BIT    = 19;
  localparam int PERI_PD_EN_BIT       = 20;

  // everything forced on and unisolated after reset
  localparam logic [31:0] PWC_RESET    = 32'h0009_2925;
  localparam logic [31:0] PWC_WR_MASK  = 32'h001f_ffff;

  // domain numbering
  localparam int DOM_PERI  = 0;
  localparam int DOM_SLOW  = 1;
  localparam int DOM_FAST  = 2;
  localparam int NUM_DOMS  = 3;

  // per-domain control fields as decoded from the register
  typedef struct packed {
    logic sleep_pd_en;
    logic force_on;
    logic force_off;
    logic lp_force_on;
    logic lp_force_off;
    logic follow_cpu_sel;
    logic force_isolate;
    logic force_unisolate;
  } dom_ctrl_s;

  // per-domain switch outputs
  typedef struct packed {
    logic power_on;
    logic isolate;
  } dom_out_s;

  localparam dom_out_s DOM_OUT_RESET = '{power_on: 1'b1, isolate: 1'b0};

endpackage : lp_pwr_pkg

// ==== sim/low_power_domain_power_control_tb.sv ====
`timescale 1ns/1ps
module low_power_domain_power_control_tb;
  import lp_pwr_pkg::*;
  logic        pclk = 0, presetn = 0, ce = 1, psel = 0, penable = 0, pwrite = 0;
  logic        sleep_active = 0, lp_mode = 0, cpu_pd = 0, pready, pslverr, e;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, prdata, q;
  logic [3:0]  pstrb = 4'hf;
  logic        periph_power_on, periph_isolate, slow_mem_power_on;
  logic        slow_mem_isolate, fast_mem_power_on, fast_mem_isolate;
  int          n_fail = 0, checks = 0;
  // control word, {sleep, lp, cpu}, {fast iso/on, slow iso/on, periph iso/on}
  logic [29:0] tbl [11] = '{
    {21'h000000, 3'b000, 6'b010101}, {21'h124000, 3'b100, 6'b101010},
    {21'h124240, 3'b011, 6'b101001}, {21'h124240, 3'b110, 6'b010110},
    {21'h1b6000, 3'b100, 6'b010101}, {21'h049000, 3'b000, 6'b101010},
    {21'h124880, 3'b110, 6'b100110}, {21'h000500, 3'b010, 6'b011001},
    {21'h000500, 3'b000, 6'b010101}, {21'h00001a, 3'b000, 6'b111111},
    {21'h049025, 3'b000, 6'b000000}};

  low_power_domain_power_control dut (.*);

  initial begin
    forever #10 pclk = ~pclk;
  end

  // an idle edge first keeps back-to-back calls from assigning psel twice in one step
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    q = prdata;
    e = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask : xfer

  task automatic chk(input logic [31:0] s, input logic [31:0] x);
    checks++;
    if (s !== x) begin
      n_fail++;
      $display("MISMATCH %0t seen %h expected %h", $time, s, x);
    end
  endtask : chk

  task automatic tally_and_finish;
    $display("checks %0d failures %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : tally_and_finish

  // watchdog, far beyond the roughly 160 cycles the run needs
  initial begin
    #100us;
    n_fail++;
    tally_and_finish();
  end

  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    xfer(1'b0, PWC_ADDR, 32'h0);
    chk(q, PWC_RESET);
    chk({fast_mem_isolate, fast_mem_power_on, slow_mem_isolate, slow_mem_power_on,
         periph_isolate, periph_power_on}, 32'h15);
    foreach (tbl[i]) begin
      {sleep_active, lp_mode, cpu_pd} <= tbl[i][8:6];
      xfer(1'b1, PWC_ADDR, {11'h000, tbl[i][29:9]});
      repeat (2) @(posedge pclk);
      chk({fast_mem_isolate, fast_mem_power_on, slow_mem_isolate, slow_mem_power_on,
           periph_isolate, periph_power_on}, tbl[i][5:0]);
      xfer(1'b0, STATUS_ADDR, 32'h0);
      chk(q, tbl[i][5:0]);
      xfer(1'b0, PWC_ADDR, 32'h0);
      chk(q, {11'h000, tbl[i][29:9]});
    end
    // status is read only and a hole answers with an error
    xfer(1'b1, STATUS_ADDR, 32'hffff_ffff);
    xfer(1'b0, PWC_ADDR, 32'h0);
    chk(q, 32'h0004_9025);
    xfer(1'b0, 12'hff0, 32'h0);
    chk(e, 32'h1);
    chk(q, 32'h0);
    // one byte lane only: lane 2 clears periph force-off, the other lanes keep their bits
    pstrb <= 4'h4;
    xfer(1'b1, PWC_ADDR, 32'h0000_0000);
    pstrb <= 4'hf;
    repeat (2) @(posedge pclk);
    chk({fast_mem_isolate, fast_mem_power_on, slow_mem_isolate, slow_mem_power_on,
         periph_isolate, periph_power_on}, 32'h01);
    xfer(1'b0, PWC_ADDR, 32'h0);
    chk(q, 32'h0000_9025);
    chk(e, 32'h0);
    // with the enable low a write must not be taken and the switches must hold
    ce <= 1'b0;
    xfer(1'b1, PWC_ADDR, 32'h0004_9000);
    repeat (2) @(posedge pclk);
    chk({fast_mem_isolate, fast_mem_power_on, slow_mem_isolate, slow_mem_power_on,
         periph_isolate, periph_power_on}, 32'h01);
    ce <= 1'b1;
    xfer(1'b0, PWC_ADDR, 32'h0);
    chk(q, 32'h0000_9025);
    tally_and_finish();
  end
endmodule : low_power_domain_power_control_tb

// ==== sim/lp_pwr_asserts.sv ====
`timescale 1ns/1ps
module lp_pwr_asserts
  import lp_pwr_pkg::*;
(
  // clock, reset and enable
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        ce,
  // apb
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb,
  // sequencer and cpu
  input wire logic        sleep_active,
  input wire logic        lp_mode,
  input wire logic        cpu_pd,
  // switches
  input wire logic        periph_power_on,
  input wire logic        periph_isolate,
  input wire logic        slow_mem_power_on,
  input wire logic        slow_mem_isolate,
  input wire logic        fast_mem_power_on,
  input wire logic        fast_mem_isolate
);
  logic [31:0] r, next_r, m;
  // shadow of the control word so switch checks need no internal probes
  always_comb begin
    m = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}} & PWC_WR_MASK;
    next_r = r;
    if (ce && psel && penable && pwrite && paddr == PWC_ADDR) next_r = (r & ~m) | (pwdata & m);
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) r <= PWC_RESET;
    else r <= next_r;
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  peri_on_a: assert property (ce && r[19] |=> periph_power_on)
    else $error("periph not held on");
  peri_sleep_a: assert property (ce && r[20] && sleep_active && r[19:18] == 2'b00
    |=> !periph_power_on) else $error("periph on in sleep");
  peri_iso_a: assert property (ce && r[4] |=> periph_isolate)
    else $error("periph not isolated");
  slow_off_a: assert property (ce && r[16:15] == 2'b01 |=> !slow_mem_power_on)
    else $error("slow memory not off");
  slow_lp_a: assert property (ce && r[16:15] == 2'b00 && lp_mode && r[11]
    |=> slow_mem_power_on) else $error("slow memory not on in low power");
  slow_cpu_a: assert property (ce && r[16:15] == 2'b00 && r[11:9] == 3'b001 && r[17]
    && lp_mode |=> slow_mem_power_on == !$past(cpu_pd)) else $error("slow memory ignores cpu");
  fast_seq_a: assert property (ce && r[13:12] == 2'b00 && r[8:6] == 3'b000 && r[14]
    && sleep_active |=> !fast_mem_power_on) else $error("fast memory on in sleep");
  slow_uniso_a: assert property (ce && r[3:2] == 2'b01 |=> !slow_mem_isolate)
    else $error("slow memory isolated");
  fast_iso_a: assert property (ce && r[1] |=> fast_mem_isolate)
    else $error("fast memory not isolated");
endmodule : lp_pwr_asserts

bind low_power_domain_power_control lp_pwr_asserts u_chk (.*);
